// file: hw/opdec_top.sv
// Operand field decoder with its Wishbone register file.
// Assumes fetch supplies word, valid strobe and format on clk_i.
//
// Operation
// - Access bit 0: access region, bank ignored
// - Access bit 1: bank from bank register
// - Three-bit index picks bit 0 to 7
// - Dest bit 0 accumulator, 1 file register
// - Short file address is 8 bits
// - Move source address is 12 bits
// - Move target address is 12 bits
// - Literal is 8, 12 or 20 bits
// - Table mode: keep, post-inc, post-dec, pre-inc
// - Branch offset signed, call target absolute
// - Fast bit selects shadow save or restore
// - Don't-care bits ignored, zero recommended
// - 21-bit table pointer, 8-bit table latch
// - Five ALU status flags updated
// - Product held as two addressable bytes
// - Program counter high and upper latches
// - Lone second word behaves as no-op
// - Operands valid within four-period cycle
`timescale 1ns/1ps
module opdec_top #(
  parameter logic [opdec_pkg::F8_W-1:0] ACCESS_SPLIT = 8'h80,
  parameter logic [opdec_pkg::BANK_W-1:0] ACCESS_HI_BANK = 4'hf
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  input opdec_pkg::opdec_fmt_type fmt_i,
  input wire logic [4:0] alu_flags_i,
  input wire logic alu_flags_we_i,
  input wire logic [15:0] prod_i,
  input wire logic prod_we_i,
  input wire logic [7:0] tbl_data_i,
  input wire logic tbl_data_we_i,
  input wire logic [7:0] pc_low_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic dec_valid_o,
  output opdec_pkg::opdec_fmt_type class_o,
  output logic [11:0] ram_addr_o,
  output logic [2:0] bit_index_o,
  output logic [7:0] bit_mask_o,
  output logic dest_file_o,
  output logic [7:0] file_addr_o,
  output logic [11:0] src_addr_o,
  output logic [11:0] dst_addr_o,
  output logic [19:0] literal_o,
  output logic [4:0] lit_width_o,
  output logic branch_rel_o,
  output logic [20:0] branch_off_o,
  output logic branch_abs_o,
  output logic fast_o,
  output opdec_pkg::opdec_tbl_type tbl_mode_o,
  output logic [20:0] tbl_addr_o,
  output logic [7:0] pc_high_latch_o,
  output logic [4:0] pc_upper_latch_o
);

  opdec_pkg::opdec_state_type state_r, state_nxt;
  opdec_pkg::opdec_fmt_type first_fmt_r, first_fmt_nxt, class_nxt;
  opdec_pkg::opdec_tbl_type tbl_mode_nxt;
  logic [15:0] first_r, first_nxt;
  logic [3:0] bank_r;
  logic [20:0] tbl_ptr_r, tbl_ptr_nxt, tbl_addr_nxt;
  logic [7:0] tbl_latch_r, prod_lo_r, prod_hi_r, pc_low_r;
  logic [4:0] flags_r, lit_width_nxt;
  logic valid_nxt, dest_nxt, rel_nxt, abs_nxt, fast_nxt, tbl_upd;
  logic use_ram, is_tag;
  logic [2:0] bit_idx_nxt;
  logic [7:0] bit_mask_nxt, file_nxt;
  logic [11:0] ram_nxt, src_nxt, dst_nxt;
  logic [19:0] lit_nxt;
  logic [20:0] off_nxt;
  logic wb_req, wb_wr;
  logic [7:0] adr_w;
  logic [31:0] rd_nxt, merged;

  opdec_ram_if ram_bus ();

  opdec_ram_addr #(
    .ACCESS_SPLIT(ACCESS_SPLIT),
    .ACCESS_HI_BANK(ACCESS_HI_BANK)
  ) u_ram_addr (
    .ram_io(ram_bus.calc)
  );

  ////////////////////////////////////////////////////////////////////////
  // Field extraction
  assign is_tag = instr_i[opdec_pkg::TAG_MSB:opdec_pkg::TAG_LSB] ==
                  opdec_pkg::SECOND_WORD_TAG;
  assign ram_bus.access_sel = instr_i[opdec_pkg::POS_ACCESS];
  assign ram_bus.bank = bank_r;
  assign ram_bus.file_addr = instr_i[opdec_pkg::F8_MSB:0];

  always_comb begin
    valid_nxt = 1'b0;
    class_nxt = opdec_pkg::FMT_NONE;
    state_nxt = state_r;
    first_nxt = first_r;
    first_fmt_nxt = first_fmt_r;
    use_ram = 1'b0;
    dest_nxt = 1'b0;
    bit_idx_nxt = 3'h0;
    bit_mask_nxt = 8'h00;
    file_nxt = 8'h00;
    src_nxt = 12'h000;
    dst_nxt = 12'h000;
    lit_nxt = 20'h00000;
    lit_width_nxt = 5'h00;
    rel_nxt = 1'b0;
    abs_nxt = 1'b0;
    off_nxt = 21'h000000;
    fast_nxt = 1'b0;
    tbl_mode_nxt = opdec_pkg::TBL_KEEP;
    tbl_upd = 1'b0;
    tbl_ptr_nxt = tbl_ptr_r;
    tbl_addr_nxt = 21'h000000;
    if (instr_valid_i && state_r == opdec_pkg::ST_SECOND) begin
      state_nxt = opdec_pkg::ST_IDLE;
      valid_nxt = 1'b1;
      class_nxt = first_fmt_r;
      case (first_fmt_r)
        opdec_pkg::FMT_MOVE: begin
          src_nxt = first_r[opdec_pkg::F12_MSB:0];
          dst_nxt = instr_i[opdec_pkg::F12_MSB:0];
        end
        opdec_pkg::FMT_LIT12: begin
          lit_nxt = opdec_pkg::opdec_lit_type'(
            {first_r[opdec_pkg::LIT12_HI_MSB:0],
             instr_i[opdec_pkg::LIT8_MSB:0]});
          lit_width_nxt = opdec_pkg::LIT_W12;
        end
        opdec_pkg::FMT_CALL, opdec_pkg::FMT_GOTO: begin
          lit_nxt = {instr_i[opdec_pkg::F12_MSB:0],
                     first_r[opdec_pkg::LIT8_MSB:0]};
          lit_width_nxt = opdec_pkg::LIT_W20;
          abs_nxt = 1'b1;
          fast_nxt = (first_fmt_r == opdec_pkg::FMT_CALL) &&
                     first_r[opdec_pkg::POS_FAST_CALL];
        end
        default: begin
        end
      endcase
    end else if (instr_valid_i && is_tag) begin
      valid_nxt = 1'b1;
      class_nxt = opdec_pkg::FMT_NOP;
    end else if (instr_valid_i) begin
      valid_nxt = 1'b1;
      class_nxt = fmt_i;
      file_nxt = instr_i[opdec_pkg::F8_MSB:0];
      case (fmt_i)
        opdec_pkg::FMT_BYTE: begin
          use_ram = 1'b1;
          dest_nxt = instr_i[opdec_pkg::POS_DEST];
        end
        opdec_pkg::FMT_BIT: begin
          use_ram = 1'b1;
          bit_idx_nxt = instr_i[opdec_pkg::BIT_MSB:opdec_pkg::BIT_LSB];
          bit_mask_nxt = 8'h01 << bit_idx_nxt;
        end
        opdec_pkg::FMT_LIT8: begin
          file_nxt = 8'h00;
          lit_nxt = opdec_pkg::opdec_lit_type'(
            instr_i[opdec_pkg::LIT8_MSB:0]);
          lit_width_nxt = opdec_pkg::LIT_W8;
        end
        opdec_pkg::FMT_MOVE, opdec_pkg::FMT_LIT12,
        opdec_pkg::FMT_CALL, opdec_pkg::FMT_GOTO: begin
          valid_nxt = 1'b0;
          class_nxt = opdec_pkg::FMT_NONE;
          file_nxt = 8'h00;
          state_nxt = opdec_pkg::ST_SECOND;
          first_nxt = instr_i;
          first_fmt_nxt = fmt_i;
        end
        opdec_pkg::FMT_BRA: begin
          file_nxt = 8'h00;
          rel_nxt = 1'b1;
          off_nxt = opdec_pkg::opdec_pc_type'(
            $signed(instr_i[opdec_pkg::BRA_MSB:0]));
        end
        opdec_pkg::FMT_BRC: begin
          file_nxt = 8'h00;
          rel_nxt = 1'b1;
          off_nxt = opdec_pkg::opdec_pc_type'(
            $signed(instr_i[opdec_pkg::BRC_MSB:0]));
        end
        opdec_pkg::FMT_RET: begin
          file_nxt = 8'h00;
          fast_nxt = instr_i[opdec_pkg::POS_FAST_RET];
        end
        opdec_pkg::FMT_TABLE: begin
          file_nxt = 8'h00;
          tbl_mode_nxt = opdec_pkg::opdec_tbl_type'(
            instr_i[opdec_pkg::TBL_MSB:0]);
          tbl_upd = tbl_mode_nxt != opdec_pkg::TBL_KEEP;
          tbl_addr_nxt = tbl_ptr_r;
          if (tbl_mode_nxt == opdec_pkg::TBL_POST_DEC) begin
            tbl_ptr_nxt = tbl_ptr_r - 21'h000001;
          end else if (tbl_mode_nxt != opdec_pkg::TBL_KEEP) begin
            tbl_ptr_nxt = tbl_ptr_r + 21'h000001;
          end
          if (tbl_mode_nxt == opdec_pkg::TBL_PRE_INC) begin
            tbl_addr_nxt = tbl_ptr_nxt;
          end
        end
        default: begin
          file_nxt = 8'h00;
        end
      endcase
    end
    ram_nxt = use_ram ? ram_bus.full_addr : 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= opdec_pkg::ST_IDLE;
      first_r <= 16'h0000;
      first_fmt_r <= opdec_pkg::FMT_NONE;
    end else begin
      state_r <= state_nxt;
      first_r <= first_nxt;
      first_fmt_r <= first_fmt_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_valid_o <= 1'b0;
      class_o <= opdec_pkg::FMT_NONE;
      ram_addr_o <= 12'h000;
      bit_index_o <= 3'h0;
      bit_mask_o <= 8'h00;
      dest_file_o <= 1'b0;
      file_addr_o <= 8'h00;
      src_addr_o <= 12'h000;
      dst_addr_o <= 12'h000;
      literal_o <= 20'h00000;
      lit_width_o <= 5'h00;
      branch_rel_o <= 1'b0;
      branch_off_o <= 21'h000000;
      branch_abs_o <= 1'b0;
      fast_o <= 1'b0;
      tbl_mode_o <= opdec_pkg::TBL_KEEP;
      tbl_addr_o <= 21'h000000;
    end else begin
      dec_valid_o <= valid_nxt;
      class_o <= class_nxt;
      ram_addr_o <= ram_nxt;
      bit_index_o <= bit_idx_nxt;
      bit_mask_o <= bit_mask_nxt;
      dest_file_o <= dest_nxt;
      file_addr_o <= file_nxt;
      src_addr_o <= src_nxt;
      dst_addr_o <= dst_nxt;
      literal_o <= lit_nxt;
      lit_width_o <= lit_width_nxt;
      branch_rel_o <= rel_nxt;
      branch_off_o <= off_nxt;
      branch_abs_o <= abs_nxt;
      fast_o <= fast_nxt;
      tbl_mode_o <= tbl_mode_nxt;
      tbl_addr_o <= tbl_addr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after request, unmapped reads zero
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign adr_w = {wb_adr_i[7:2], 2'b00};
  assign merged = lane_merge(rd_nxt, wb_dat_i, wb_sel_i);

  always_comb begin
    if (adr_w == opdec_pkg::OFF_BANK) begin
      rd_nxt = 32'(bank_r);
    end else if (adr_w == opdec_pkg::OFF_TABLE_POINTER) begin
      rd_nxt = 32'(tbl_ptr_r);
    end else if (adr_w == opdec_pkg::OFF_TBLLAT) begin
      rd_nxt = 32'(tbl_latch_r);
    end else if (adr_w == opdec_pkg::OFF_PROD_LO) begin
      rd_nxt = 32'(prod_lo_r);
    end else if (adr_w == opdec_pkg::OFF_PROD_HI) begin
      rd_nxt = 32'(prod_hi_r);
    end else if (adr_w == opdec_pkg::OFF_FLAGS) begin
      rd_nxt = 32'(flags_r);
    end else if (adr_w == opdec_pkg::OFF_PC_LOW) begin
      rd_nxt = 32'(pc_low_r);
    end else if (adr_w == opdec_pkg::OFF_PC_HIGH) begin
      rd_nxt = 32'(pc_high_latch_o);
    end else if (adr_w == opdec_pkg::OFF_PC_UPPER) begin
      rd_nxt = 32'(pc_upper_latch_o);
    end else if (adr_w == opdec_pkg::OFF_DECSTAT) begin
      rd_nxt = 32'({first_fmt_r, state_r, class_o});
    end else begin
      rd_nxt = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_nxt : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; hardware updates win over a same-cycle bus write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_r <= opdec_pkg::BANK_RST;
    end else if (wb_wr && adr_w == opdec_pkg::OFF_BANK) begin
      bank_r <= merged[opdec_pkg::BANK_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbl_ptr_r <= opdec_pkg::TABLE_POINTER_RST;
    end else if (tbl_upd) begin
      tbl_ptr_r <= tbl_ptr_nxt;
    end else if (wb_wr && adr_w == opdec_pkg::OFF_TABLE_POINTER) begin
      tbl_ptr_r <= merged[opdec_pkg::PC_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbl_latch_r <= opdec_pkg::BYTE_RST;
    end else if (tbl_data_we_i) begin
      tbl_latch_r <= tbl_data_i;
    end else if (wb_wr && adr_w == opdec_pkg::OFF_TBLLAT) begin
      tbl_latch_r <= merged[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prod_lo_r <= opdec_pkg::BYTE_RST;
      prod_hi_r <= opdec_pkg::BYTE_RST;
    end else if (prod_we_i) begin
      prod_lo_r <= prod_i[7:0];
      prod_hi_r <= prod_i[15:8];
    end else if (wb_wr && adr_w == opdec_pkg::OFF_PROD_LO) begin
      prod_lo_r <= merged[7:0];
    end else if (wb_wr && adr_w == opdec_pkg::OFF_PROD_HI) begin
      prod_hi_r <= merged[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= opdec_pkg::FLAGS_RST;
    end else if (alu_flags_we_i) begin
      flags_r <= alu_flags_i;
    end else if (wb_wr && adr_w == opdec_pkg::OFF_FLAGS) begin
      flags_r <= merged[opdec_pkg::FLAG_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_low_r <= opdec_pkg::BYTE_RST;
      pc_high_latch_o <= opdec_pkg::BYTE_RST;
      pc_upper_latch_o <= opdec_pkg::UPPER_RST;
    end else begin
      pc_low_r <= pc_low_i;
      if (wb_wr && adr_w == opdec_pkg::OFF_PC_HIGH) begin
        pc_high_latch_o <= merged[7:0];
      end
      if (wb_wr && adr_w == opdec_pkg::OFF_PC_UPPER) begin
        pc_upper_latch_o <= merged[opdec_pkg::UPPER_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // access region
  chk_access_ram: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (instr_valid_i && state_r == opdec_pkg::ST_IDLE && !is_tag &&
     fmt_i == opdec_pkg::FMT_BYTE && !instr_i[8] &&
     instr_i[7:0] < ACCESS_SPLIT) |=> ram_addr_o[11:8] == 4'h0)
    else $error("Access region not selected");

  chk_bank_sel: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (instr_valid_i && state_r == opdec_pkg::ST_IDLE && !is_tag &&
     fmt_i == opdec_pkg::FMT_BIT && instr_i[8])
    |=> ram_addr_o == {$past(bank_r), $past(instr_i[7:0])})
    else $error("Bank register not used");

  chk_bit_mask: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (instr_valid_i && state_r == opdec_pkg::ST_IDLE && !is_tag &&
     fmt_i == opdec_pkg::FMT_BIT)
    |=> bit_mask_o == (8'h01 << $past(instr_i[11:9])))
    else $error("Bit mask wrong");

  chk_dest_sel: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (instr_valid_i && state_r == opdec_pkg::ST_IDLE && !is_tag &&
     fmt_i == opdec_pkg::FMT_BYTE) |=> dest_file_o == $past(instr_i[9]))
    else $error("Destination select wrong");

  chk_move_addr: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (instr_valid_i && state_r == opdec_pkg::ST_SECOND &&
     first_fmt_r == opdec_pkg::FMT_MOVE)
    |=> dec_valid_o && dst_addr_o == $past(instr_i[11:0]) &&
        src_addr_o == $past(first_r[11:0]))
    else $error("Move addresses wrong");

  chk_tbl_step: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (instr_valid_i && state_r == opdec_pkg::ST_IDLE && !is_tag &&
     fmt_i == opdec_pkg::FMT_TABLE && instr_i[1:0] == 2'h1)
    |=> tbl_ptr_r == $past(tbl_ptr_r) + 21'h000001 &&
        tbl_addr_o == $past(tbl_ptr_r))
    else $error("Table pointer step wrong");

  chk_branch_sext: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (instr_valid_i && state_r == opdec_pkg::ST_IDLE && !is_tag &&
     fmt_i == opdec_pkg::FMT_BRA && instr_i[10])
    |=> branch_rel_o && branch_off_o[20:11] == 10'h3ff)
    else $error("Branch offset not sign extended");

  chk_lone_nop: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (instr_valid_i && state_r == opdec_pkg::ST_IDLE && is_tag)
    |=> dec_valid_o && class_o == opdec_pkg::FMT_NOP && literal_o == 0)
    else $error("Lone second word not a no-op");

  chk_unused_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (dec_valid_o && class_o == opdec_pkg::FMT_LIT8)
    |-> file_addr_o == 8'h00 && ram_addr_o == 12'h000 && !fast_o)
    else $error("Unused field not zero");

endmodule // opdec_top

// file: hw/opdec_pkg.sv
// Shared constants and types of the operand field decoder.
// Assumes 16-bit instruction words and one core clock domain.
package opdec_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int INSTR_W = 16;
  localparam int BANK_W = 4;
  localparam int F8_W = 8;
  localparam int F12_W = 12;
  localparam int LIT_W = 20;
  localparam int PC_W = 21;
  localparam int UPPER_W = 5;
  localparam int FLAG_W = 5;
  localparam int OSC_PER_ICYC = 4;

  typedef logic [PC_W-1:0] opdec_pc_type;
  typedef logic [LIT_W-1:0] opdec_lit_type;
  typedef logic [F12_W-1:0] opdec_f12_type;

  ////////////////////////////////////////////////////////////////////////
  // Field positions inside a word
  localparam int F8_MSB = 7;
  localparam int F12_MSB = 11;
  localparam int POS_ACCESS = 8;
  localparam int POS_DEST = 9;
  localparam int BIT_LSB = 9;
  localparam int BIT_MSB = 11;
  localparam int LIT8_MSB = 7;
  localparam int LIT12_HI_MSB = 3;
  localparam int BRA_MSB = 10;
  localparam int BRC_MSB = 7;
  localparam int POS_FAST_CALL = 8;
  localparam int POS_FAST_RET = 0;
  localparam int TBL_MSB = 1;
  localparam int TAG_LSB = 12;
  localparam int TAG_MSB = 15;
  localparam logic [3:0] SECOND_WORD_TAG = 4'hf;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;

  // Flag bit positions in the status register
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_HALF_CARRY = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_SIGNED_WRAP = 3;
  localparam int FLAG_NEGATIVE = 4;

  // Literal widths reported with the literal
  localparam logic [4:0] LIT_W8 = 5'h08;
  localparam logic [4:0] LIT_W12 = 5'h0c;
  localparam logic [4:0] LIT_W20 = 5'h14;

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets and reset values
  localparam logic [7:0] OFF_BANK = 8'h00;
  localparam logic [7:0] OFF_TABLE_POINTER = 8'h04;
  localparam logic [7:0] OFF_TBLLAT = 8'h08;
  localparam logic [7:0] OFF_PROD_LO = 8'h0c;
  localparam logic [7:0] OFF_PROD_HI = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_PC_LOW = 8'h18;
  localparam logic [7:0] OFF_PC_HIGH = 8'h1c;
  localparam logic [7:0] OFF_PC_UPPER = 8'h20;
  localparam logic [7:0] OFF_DECSTAT = 8'h24;
  localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
  localparam logic [PC_W-1:0] TABLE_POINTER_RST = 21'h000000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
  localparam logic [UPPER_W-1:0] UPPER_RST = 5'h00;

  ////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic [3:0] {
    FMT_NONE = 4'h0, FMT_BYTE = 4'h1, FMT_BIT = 4'h2, FMT_LIT8 = 4'h3,
    FMT_LIT12 = 4'h4, FMT_MOVE = 4'h5, FMT_CALL = 4'h6, FMT_GOTO = 4'h7,
    FMT_BRA = 4'h8, FMT_BRC = 4'h9, FMT_RET = 4'ha, FMT_TABLE = 4'hb,
    FMT_NOP = 4'hc
  } opdec_fmt_type;

  typedef enum logic [1:0] {
    TBL_KEEP = 2'h0, TBL_POST_INC = 2'h1, TBL_POST_DEC = 2'h2,
    TBL_PRE_INC = 2'h3
  } opdec_tbl_type;

  typedef enum logic {ST_IDLE = 1'b0, ST_SECOND = 1'b1} opdec_state_type;

endpackage

// file: hw/opdec_ram_if.sv
// Carries one RAM address request between decoder and address former.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface opdec_ram_if;
  logic access_sel;
  logic [opdec_pkg::BANK_W-1:0] bank;
  logic [opdec_pkg::F8_W-1:0] file_addr;
  logic [opdec_pkg::F12_W-1:0] full_addr;
  modport calc (input access_sel, input bank, input file_addr,
                output full_addr);
  modport user (output access_sel, output bank, output file_addr,
                input full_addr);
endinterface

// file: hw/opdec_ram_addr.sv
// Forms the 12-bit data RAM address from access bit, bank and offset.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
module opdec_ram_addr #(
  parameter logic [opdec_pkg::F8_W-1:0] ACCESS_SPLIT = 8'h80,
  parameter logic [opdec_pkg::BANK_W-1:0] ACCESS_HI_BANK = 4'hf
) (
  opdec_ram_if.calc ram_io
);

  always_comb begin
    if (ram_io.access_sel) begin
      ram_io.full_addr = {ram_io.bank, ram_io.file_addr};
    end else if (ram_io.file_addr < ACCESS_SPLIT) begin
      ram_io.full_addr = {opdec_pkg::ACCESS_LO_BANK, ram_io.file_addr};
    end else begin
      ram_io.full_addr = {ACCESS_HI_BANK, ram_io.file_addr};
    end
  end

endmodule // opdec_ram_addr

// file: test/opdec_fetch_model.sv
// Fetch-stage model: hands the decoder one word with a one-cycle valid.
// Assumes the bench calls send from one thread, in clk_i's domain.
`timescale 1ns/1ps
module opdec_fetch_model (
  input wire logic clk_i,
  output logic [15:0] instr_o,
  output logic valid_o,
  output opdec_pkg::opdec_fmt_type fmt_o
);
  initial begin
    instr_o = 16'h0000;
    valid_o = 1'b0;
    fmt_o = opdec_pkg::FMT_NONE;
  end
  task automatic send(input logic [15:0] w,
      input opdec_pkg::opdec_fmt_type f);
    @(posedge clk_i);
    instr_o <= w;
    fmt_o <= f;
    valid_o <= 1'b1;
    @(posedge clk_i);
    valid_o <= 1'b0;
    // Inverted idle word, so a stale word never passes as a fresh one
    instr_o <= ~w;
    #1;
  endtask
endmodule // opdec_fetch_model

// file: test/tb.sv
// Self-checking bench of the operand decoder and its register file.
// Assumes default parameters: access split 0x80, upper access bank 0xf.
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic instr_valid_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dec_valid_o;
  logic alu_flags_we_i, prod_we_i, tbl_data_we_i, dest_file_o, fast_o;
  logic branch_rel_o, branch_abs_o;
  opdec_pkg::opdec_fmt_type fmt_i, class_o;
  opdec_pkg::opdec_tbl_type tbl_mode_o;
  logic [15:0] instr_i, prod_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [7:0] wb_adr_i, tbl_data_i, pc_low_i, bit_mask_o, file_addr_o;
  logic [7:0] pc_high_latch_o;
  logic [4:0] alu_flags_i, lit_width_o, pc_upper_latch_o;
  logic [3:0] wb_sel_i;
  logic [2:0] bit_index_o;
  logic [11:0] ram_addr_o, src_addr_o, dst_addr_o;
  logic [19:0] literal_o;
  logic [20:0] branch_off_o, tbl_addr_o;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  opdec_top u_dut (.*);
  opdec_fetch_model u_fetch (.clk_i, .instr_o(instr_i),
    .valid_o(instr_valid_i), .fmt_o(fmt_i));
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits for ack without assuming latency; read data taken at that edge
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    int n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    // A missing ack ends the run at once, counted as a mismatch
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic t_byte;
    wb(1, 8'h00, 32'h5, q);
    wb(0, 8'h00, 32'h0, q);
    chk(q, 32'h5);
    u_fetch.send(16'h0312, opdec_pkg::FMT_BYTE);
    chk({dec_valid_o, dest_file_o, ram_addr_o, file_addr_o},
      {2'h3, 12'h512, 8'h12});
    u_fetch.send(16'h0090, opdec_pkg::FMT_BYTE);
    chk({dest_file_o, ram_addr_o}, {1'b0, 12'hf90});
    u_fetch.send(16'h0012, opdec_pkg::FMT_BYTE);
    chk(ram_addr_o, 12'h012);
    u_fetch.send(16'h01ff, opdec_pkg::FMT_BYTE);
    chk({dest_file_o, ram_addr_o}, {1'b0, 12'h5ff});
    u_fetch.send(16'h0b34, opdec_pkg::FMT_BIT);
    chk({bit_index_o, bit_mask_o, ram_addr_o},
      {3'h5, 8'h20, 12'h534});
    $display("test byte done");
  endtask
  task automatic t_two;
    u_fetch.send(16'hcabc, opdec_pkg::FMT_MOVE);
    chk(dec_valid_o, 1'b0);
    u_fetch.send(16'hf123, opdec_pkg::FMT_NONE);
    chk({class_o, src_addr_o, dst_addr_o},
      {opdec_pkg::FMT_MOVE, 12'habc, 12'h123});
    u_fetch.send(16'h0e7f, opdec_pkg::FMT_LIT8);
    chk({literal_o, lit_width_o}, {20'h0007f, 5'h08});
    u_fetch.send(16'hee03, opdec_pkg::FMT_LIT12);
    u_fetch.send(16'hf0c5, opdec_pkg::FMT_NONE);
    chk({literal_o, lit_width_o}, {20'h003c5, 5'h0c});
    u_fetch.send(16'hef56, opdec_pkg::FMT_GOTO);
    u_fetch.send(16'hf9ab, opdec_pkg::FMT_NONE);
    chk({literal_o, lit_width_o, branch_abs_o},
      {20'h9ab56, 5'h14, 1'b1});
    u_fetch.send(16'hed34, opdec_pkg::FMT_CALL);
    u_fetch.send(16'hf001, opdec_pkg::FMT_NONE);
    chk({literal_o, fast_o}, {20'h00134, 1'b1});
    u_fetch.send(16'h0012, opdec_pkg::FMT_RET);
    chk(fast_o, 1'b0);
    u_fetch.send(16'hd7ff, opdec_pkg::FMT_BRA);
    chk({branch_rel_o, branch_off_o}, {1'b1, 21'h1fffff});
    u_fetch.send(16'hf0aa, opdec_pkg::FMT_BYTE);
    chk({class_o, file_addr_o, ram_addr_o},
      {opdec_pkg::FMT_NOP, 20'h0});
    @(posedge clk_i);
    #1;
    chk({class_o, literal_o, dec_valid_o}, 25'h0);
    $display("test two-word done");
  endtask
  task automatic t_regs;
    logic [20:0] p = 21'h10;
    wb(1, 8'h04, 32'h10, q);
    for (int k = 0; k < 4; k++) begin
      u_fetch.send({14'h0002, 2'(k)}, opdec_pkg::FMT_TABLE);
      if (k == 3) p++;
      chk({tbl_mode_o, tbl_addr_o}, {2'(k), p});
      if (k == 1) p++;
      if (k == 2) p--;
      wb(0, 8'h04, 32'h0, q);
      chk(q, {11'h0, p});
    end
    @(posedge clk_i);
    {alu_flags_we_i, prod_we_i, tbl_data_we_i} <= 3'h7;
    {alu_flags_i, prod_i, tbl_data_i} <= {5'h15, 16'hbeef, 8'h9c};
    @(posedge clk_i);
    {alu_flags_we_i, prod_we_i, tbl_data_we_i} <= 3'h0;
    wb(0, 8'h14, 32'h0, q);
    chk(q, 32'h15);
    wb(0, 8'h10, 32'h0, q);
    chk(q, 32'hbe);
    wb(0, 8'h0c, 32'h0, q);
    chk(q, 32'hef);
    wb(0, 8'h08, 32'h0, q);
    chk(q, 32'h9c);
    wb(1, 8'h20, 32'hff, q);
    wb(1, 8'h1c, 32'h1a5, q);
    chk({pc_upper_latch_o, pc_high_latch_o}, 13'h1fa5);
    wb(1, 8'h18, 32'h55, q);
    wb(0, 8'h18, 32'h0, q);
    chk(q, 32'h3c);
    wb(1, 8'h30, 32'h7, q);
    wb(0, 8'h30, 32'h0, q);
    chk(q, 32'h0);
    $display("test registers done");
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, alu_flags_we_i, prod_we_i} = 5'h0;
    {tbl_data_we_i, wb_adr_i, wb_dat_i, alu_flags_i, prod_i} = 62'h0;
    {wb_sel_i, tbl_data_i, pc_low_i} = 20'hf003c;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_byte();
    t_two();
    t_regs();
    wrap_up();
  end
endmodule // tb
